//--- cpu_ops_pkg.sv
`default_nettype none
package cpu_ops_pkg;
    // Opcode bytes
    localparam logic [7:0] OP_OR_W     = 8'h80; // 100000aa
    localparam logic [7:0] OP_OR_B     = 8'h90; // 100100aa
    localparam logic [7:0] OP_POP      = 8'hcc; // 110011aa
    localparam logic [7:0] OP_PUSH     = 8'hc8; // 110010aa
    localparam logic [7:0] OP_FLAG_RESTORE     = 8'hf3;
    localparam logic [7:0] OP_FLAG_SAVE    = 8'hf2;
    localparam logic [7:0] OP_RET      = 8'hf0;
    localparam logic [7:0] OP_RESET    = 8'hff;
    localparam logic [7:0] OP_RELATIVE_SHORT_SUBROUTINE_JUMP    = 8'h28; // 00101xxx
    localparam logic [7:0] OP_CARRY_FORCE_ONE     = 8'hf9;
    localparam logic [7:0] OP_SHL_W    = 8'h09;
    localparam logic [7:0] OP_SHL_B    = 8'h19;
    localparam logic [7:0] OP_SHL_L    = 8'h0d;
    localparam logic [7:0] OP_SHR_W    = 8'h08;
    localparam logic [7:0] MASK_AA     = 8'hfc;
    localparam logic [7:0] MASK_XXX    = 8'hf8;
    // Processor status word bit positions
    localparam int PSW_Z  = 15;
    localparam int PSW_N  = 14;
    localparam int PSW_V  = 13;
    localparam int PSW_VT = 12;
    localparam int PSW_C  = 11;
    localparam int PSW_ST = 8;
    // Reset values and constants
    localparam logic [15:0] PC_RESET    = 16'h2080;
    localparam logic [15:0] SP_RESET    = 16'h0018;
    localparam logic [15:0] PSW_RESET   = 16'h0000;
    localparam logic [15:0] STACK_STEP  = 16'h0002;
    localparam logic [7:0]  IMM_CNT_MAX = 8'h0f;
    localparam logic [15:0] ONCHIP_TOP  = 16'h0100;
    // State counts
    localparam logic [5:0] ST_LOGIC     = 6'h04;
    localparam logic [5:0] ST_POP_ON    = 6'h0c;
    localparam logic [5:0] ST_POP_OFF   = 6'h0e;
    localparam logic [5:0] ST_FLAG_RESTORE_ON   = 6'h09;
    localparam logic [5:0] ST_FLAG_RESTORE_OFF  = 6'h0d;
    localparam logic [5:0] ST_PUSH_ON   = 6'h08;
    localparam logic [5:0] ST_PUSH_OFF  = 6'h0c;
    localparam logic [5:0] ST_RET_ON    = 6'h0c;
    localparam logic [5:0] ST_RET_OFF   = 6'h10;
    localparam logic [5:0] ST_RESET     = 6'h10;
    localparam logic [5:0] ST_RELATIVE_SHORT_SUBROUTINE_JUMP_ON  = 6'h0d;
    localparam logic [5:0] ST_RELATIVE_SHORT_SUBROUTINE_JUMP_OFF = 6'h10;
    localparam logic [5:0] ST_CARRY_FORCE_ONE      = 6'h04;
    localparam logic [5:0] ST_SHIFT     = 6'h07;
    localparam logic [5:0] ST_SHIFT0    = 6'h08;
    localparam logic [5:0] RST_PULSE    = 6'h04;
endpackage
`default_nettype wire

//--- state_timer.sv
`timescale 1ns/100ps
`default_nettype none
// Counts down the states an instruction occupies
module state_timer (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Control
    input  wire logic       load,
    input  wire logic [5:0] count,
    output logic            expired
);
    logic [5:0] cnt_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= 6'h00;
        end else if (load) begin
            cnt_r <= count;
        end else if (cnt_r != 6'h00) begin
            cnt_r <= cnt_r - 6'h01;
        end
    end

    // High one state early, so that done closes the last state of the count
    assign expired = (cnt_r == 6'h02) && !load;
endmodule // state_timer
`default_nettype wire

//--- shift_unit.sv
`timescale 1ns/100ps
`default_nettype none
// One shift step on a 32-bit operand of width byte, word or long
module shift_unit (
    input  wire logic [31:0] val,
    input  wire logic [1:0]  width,
    input  wire logic        right,
    output logic [31:0]      res,
    output logic             out_bit,
    output logic             sign_chg
);
    logic msb_in;
    logic msb_out;

    always_comb begin
        res      = 32'h0000_0000;
        out_bit  = 1'b0;
        msb_in   = 1'b0;
        msb_out  = 1'b0;
        sign_chg = 1'b0;
        if (right) begin
            out_bit = val[0];
            res     = {1'b0, val[31:1]};
        end else begin
            unique case (width)
                2'd0: begin
                    out_bit = val[7];
                    msb_out = val[6];
                    res     = {24'h000000, val[6:0], 1'b0};
                end
                2'd1: begin
                    out_bit = val[15];
                    msb_out = val[14];
                    res     = {16'h0000, val[14:0], 1'b0};
                end
                default: begin
                    out_bit = val[31];
                    msb_out = val[30];
                    res     = {val[30:0], 1'b0};
                end
            endcase
            msb_in   = out_bit;
            sign_chg = msb_in ^ msb_out;
        end
    end
endmodule // shift_unit
`default_nettype wire

//--- cpu_exec.sv
// Summary of operation
// - Word OR, set Z N, clear C V
// - Byte OR, set Z N, clear C V
// - Pop word to destination, SP plus two
// - Restore status word, SP plus two, hold interrupts
// - SP minus two, then store pushed word
// - Push status word then clear it
// - Return loads PC from stack, SP plus two
// - Soft reset clears PROCESSOR_STATUS_WORD, PC 2080, pulses pin
// - Short call pushes PC, adds 11-bit displacement
// - Set carry only, four states
// - Count immediate 0-15 or register 16-255
// - Left shifts fill low bits with zeroes
// - Left shift flags: C, Z, N, V, VT
// - Shifts take 7 plus count, zero takes 8
// - Logical right word: zero fill, flags
// - Right shift sticky flag rule
// - Short call 13 on-chip, 16 off-chip states
`timescale 1ns/100ps
`default_nettype none
module cpu_exec (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Instruction issue
    input  wire logic        issue,
    input  wire logic [7:0]  opcode,
    input  wire logic [7:0]  disp_low,
    input  wire logic [7:0]  count_byte,
    input  wire logic [7:0]  count_reg_val,
    input  wire logic [5:0]  access_extra,
    // Operands
    input  wire logic [31:0] dest_in,
    input  wire logic [15:0] src_in,
    input  wire logic [15:0] stack_rd_data,
    input  wire logic [15:0] next_pc,
    // Results
    output logic             busy,
    output logic             done,
    output logic [31:0]      dest_out,
    output logic             dest_we,
    output logic [15:0]      stack_wr_data,
    output logic             stack_we,
    output logic [15:0]      stack_addr,
    output logic [15:0]      pc_out,
    output logic             pc_we,
    output logic [15:0]      sp_out,
    output logic [15:0]      psw_out,
    output logic             irq_hold,
    output logic             io_reinit,
    output logic             reset_pin_pulse
);
    typedef enum logic [1:0] {
        IDLE  = 2'b00,
        SHIFT = 2'b01,
        WAIT  = 2'b10
    } state_t;

    typedef enum logic [3:0] {
        K_NONE  = 4'h0, K_ORW  = 4'h1, K_ORB  = 4'h2, K_POP   = 4'h3,
        K_FLAG_RESTORE  = 4'h4, K_PUSH = 4'h5, K_FLAG_SAVE = 4'h6, K_RET  = 4'h7,
        K_RST   = 4'h8, K_RELATIVE_SHORT_SUBROUTINE_JUMP = 4'h9, K_CARRY_FORCE_ONE = 4'ha, K_SHL  = 4'hb,
        K_SHR   = 4'hc
    } kind_t;

    state_t      state_r;
    kind_t       kind;
    logic [15:0] pc_r;
    logic [15:0] sp_r;
    logic [15:0] psw_r;
    logic [31:0] work_r;
    logic [4:0]  left_r;
    logic [1:0]  width_r;
    logic        right_r;
    logic        vflag_r;
    logic        stk_r;
    logic        irqh_r;
    logic [5:0]  rpulse_r;
    logic [5:0]  tload;
    logic        tstart;
    logic        expired;
    logic [31:0] sh_res;
    logic        sh_bit;
    logic        sh_chg;
    logic [7:0]  cnt_val;
    logic [4:0]  cnt;
    logic        onchip;
    logic [15:0] sp_dn;
    logic [15:0] sp_up;
    logic [15:0] or_w;
    logic [7:0]  or_b;
    logic [15:0] disp_ext;
    logic        res_zero;
    logic        res_neg;
    logic        kind_r_is_flag_restore;

    assign onchip = sp_r < cpu_ops_pkg::ONCHIP_TOP;
    assign sp_dn  = sp_r - cpu_ops_pkg::STACK_STEP;
    assign sp_up  = sp_r + cpu_ops_pkg::STACK_STEP;
    assign or_w   = dest_in[15:0] | src_in;
    assign or_b   = dest_in[7:0] | src_in[7:0];
    assign disp_ext = {{5{opcode[2]}}, opcode[2:0], disp_low};

    // Count is immediate up to 15, else the named register's contents
    assign cnt_val = (count_byte <= cpu_ops_pkg::IMM_CNT_MAX) ? count_byte
                                                              : count_reg_val;
    assign cnt = (cnt_val > 8'h1f) ? 5'h1f : cnt_val[4:0];

    always_comb begin
        kind = K_NONE;
        if ((opcode & cpu_ops_pkg::MASK_AA) == cpu_ops_pkg::OP_OR_W) kind = K_ORW;
        else if ((opcode & cpu_ops_pkg::MASK_AA) == cpu_ops_pkg::OP_OR_B) kind = K_ORB;
        else if ((opcode & cpu_ops_pkg::MASK_AA) == cpu_ops_pkg::OP_POP) kind = K_POP;
        else if ((opcode & cpu_ops_pkg::MASK_AA) == cpu_ops_pkg::OP_PUSH) kind = K_PUSH;
        else if ((opcode & cpu_ops_pkg::MASK_XXX) == cpu_ops_pkg::OP_RELATIVE_SHORT_SUBROUTINE_JUMP) kind = K_RELATIVE_SHORT_SUBROUTINE_JUMP;
        else if (opcode == cpu_ops_pkg::OP_FLAG_RESTORE) kind = K_FLAG_RESTORE;
        else if (opcode == cpu_ops_pkg::OP_FLAG_SAVE) kind = K_FLAG_SAVE;
        else if (opcode == cpu_ops_pkg::OP_RET) kind = K_RET;
        else if (opcode == cpu_ops_pkg::OP_RESET) kind = K_RST;
        else if (opcode == cpu_ops_pkg::OP_CARRY_FORCE_ONE) kind = K_CARRY_FORCE_ONE;
        else if (opcode == cpu_ops_pkg::OP_SHL_W || opcode == cpu_ops_pkg::OP_SHL_B
                 || opcode == cpu_ops_pkg::OP_SHL_L) kind = K_SHL;
        else if (opcode == cpu_ops_pkg::OP_SHR_W) kind = K_SHR;
    end

    // State count per instruction
    always_comb begin
        tload = cpu_ops_pkg::ST_LOGIC;
        unique case (kind)
            K_ORW, K_ORB: tload = cpu_ops_pkg::ST_LOGIC + access_extra;
            K_POP:   tload = (onchip ? cpu_ops_pkg::ST_POP_ON
                                     : cpu_ops_pkg::ST_POP_OFF) + access_extra;
            K_FLAG_RESTORE:  tload = onchip ? cpu_ops_pkg::ST_FLAG_RESTORE_ON : cpu_ops_pkg::ST_FLAG_RESTORE_OFF;
            K_PUSH:  tload = (onchip ? cpu_ops_pkg::ST_PUSH_ON
                                     : cpu_ops_pkg::ST_PUSH_OFF) + access_extra;
            K_FLAG_SAVE: tload = onchip ? cpu_ops_pkg::ST_PUSH_ON : cpu_ops_pkg::ST_PUSH_OFF;
            K_RET:   tload = onchip ? cpu_ops_pkg::ST_RET_ON : cpu_ops_pkg::ST_RET_OFF;
            K_RST:   tload = cpu_ops_pkg::ST_RESET;
            K_RELATIVE_SHORT_SUBROUTINE_JUMP: tload = onchip ? cpu_ops_pkg::ST_RELATIVE_SHORT_SUBROUTINE_JUMP_ON
                                    : cpu_ops_pkg::ST_RELATIVE_SHORT_SUBROUTINE_JUMP_OFF;
            K_CARRY_FORCE_ONE:  tload = cpu_ops_pkg::ST_CARRY_FORCE_ONE;
            K_SHL, K_SHR: tload = (cnt == 5'h00) ? cpu_ops_pkg::ST_SHIFT0
                                                 : cpu_ops_pkg::ST_SHIFT + {1'b0, cnt};
            default: tload = cpu_ops_pkg::ST_LOGIC;
        endcase
    end

    assign tstart = issue && (state_r == IDLE);
    assign busy   = state_r != IDLE;

    state_timer u_timer (
        .clk     (clk),
        .sys_rst (sys_rst),
        .load    (tstart),
        .count   (tload),
        .expired (expired)
    );

    shift_unit u_shift (
        .val      (work_r),
        .width    (width_r),
        .right    (right_r),
        .res      (sh_res),
        .out_bit  (sh_bit),
        .sign_chg (sh_chg)
    );

    // Sequencer: shifts iterate one per state, then all wait out the count
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= IDLE;
        end else begin
            unique case (state_r)
                IDLE:  if (tstart) state_r <= ((kind == K_SHL || kind == K_SHR)
                                               && cnt != 5'h00) ? SHIFT : WAIT;
                SHIFT: if (left_r == 5'h01) state_r <= WAIT;
                WAIT:  if (expired) state_r <= IDLE;
                default: state_r <= IDLE;
            endcase
        end
    end

    // Shift datapath and counters
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            work_r  <= 32'h0000_0000;
            left_r  <= 5'h00;
            width_r <= 2'd1;
            right_r <= 1'b0;
            vflag_r <= 1'b0;
        end else if (tstart) begin
            work_r  <= (kind == K_SHR) ? {16'h0000, dest_in[15:0]} : dest_in;
            left_r  <= cnt;
            vflag_r <= 1'b0;
            right_r <= (kind == K_SHR);
            width_r <= (opcode == cpu_ops_pkg::OP_SHL_B) ? 2'd0
                     : (opcode == cpu_ops_pkg::OP_SHL_L) ? 2'd2 : 2'd1;
        end else if (state_r == SHIFT) begin
            work_r  <= sh_res;
            left_r  <= left_r - 5'h01;
            vflag_r <= vflag_r | sh_chg;
        end
    end

    // Stack pointer, program counter and stack access
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sp_r          <= cpu_ops_pkg::SP_RESET;
            pc_r          <= cpu_ops_pkg::PC_RESET;
            stack_addr    <= cpu_ops_pkg::SP_RESET;
            stack_wr_data <= 16'h0000;
            stack_we      <= 1'b0;
            pc_we         <= 1'b0;
            stk_r         <= 1'b0;
        end else begin
            stack_we <= 1'b0;
            pc_we    <= 1'b0;
            if (tstart) begin
                stk_r <= 1'b0;
                unique case (kind)
                    K_POP, K_FLAG_RESTORE, K_RET: begin
                        stack_addr <= sp_r;
                        sp_r       <= sp_up;
                    end
                    K_PUSH, K_FLAG_SAVE, K_RELATIVE_SHORT_SUBROUTINE_JUMP: begin
                        sp_r       <= sp_dn;
                        stack_addr <= sp_dn;
                        stack_we   <= 1'b1;
                        stack_wr_data <= (kind == K_PUSH) ? src_in
                                       : (kind == K_FLAG_SAVE) ? psw_r : next_pc;
                    end
                    default: ;
                endcase
                if (kind == K_RELATIVE_SHORT_SUBROUTINE_JUMP) begin
                    pc_r  <= next_pc + disp_ext;
                    pc_we <= 1'b1;
                end else if (kind == K_RST) begin
                    pc_r  <= cpu_ops_pkg::PC_RESET;
                    pc_we <= 1'b1;
                end else if (kind == K_RET) begin
                    stk_r <= 1'b1;
                end
            end else if (stk_r) begin
                stk_r <= 1'b0;
                pc_r  <= stack_rd_data;
                pc_we <= 1'b1;
            end
        end
    end

    // Result flags for shift results
    always_comb begin
        res_zero = 1'b0;
        res_neg  = 1'b0;
        unique case (width_r)
            2'd0: begin
                res_zero = sh_res[7:0] == 8'h00;
                res_neg  = sh_res[7];
            end
            2'd1: begin
                res_zero = sh_res[15:0] == 16'h0000;
                res_neg  = sh_res[15];
            end
            default: begin
                res_zero = sh_res == 32'h0000_0000;
                res_neg  = sh_res[31];
            end
        endcase
    end

    // Processor status word
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            psw_r <= cpu_ops_pkg::PSW_RESET;
        end else if (tstart) begin
            unique case (kind)
                K_ORW: begin
                    psw_r[cpu_ops_pkg::PSW_Z] <= or_w == 16'h0000;
                    psw_r[cpu_ops_pkg::PSW_N] <= or_w[15];
                    psw_r[cpu_ops_pkg::PSW_C] <= 1'b0;
                    psw_r[cpu_ops_pkg::PSW_V] <= 1'b0;
                end
                K_ORB: begin
                    psw_r[cpu_ops_pkg::PSW_Z] <= or_b == 8'h00;
                    psw_r[cpu_ops_pkg::PSW_N] <= or_b[7];
                    psw_r[cpu_ops_pkg::PSW_C] <= 1'b0;
                    psw_r[cpu_ops_pkg::PSW_V] <= 1'b0;
                end
                K_FLAG_SAVE, K_RST: psw_r <= cpu_ops_pkg::PSW_RESET;
                K_CARRY_FORCE_ONE: psw_r[cpu_ops_pkg::PSW_C] <= 1'b1;
                K_SHR: begin
                    psw_r[cpu_ops_pkg::PSW_ST] <= 1'b0;
                    psw_r[cpu_ops_pkg::PSW_V]  <= 1'b0;
                    // A carry left over from before must not arm the sticky flag
                    if (cnt != 5'h00) psw_r[cpu_ops_pkg::PSW_C] <= 1'b0;
                end
                K_SHL: psw_r[cpu_ops_pkg::PSW_V] <= 1'b0;
                default: ;
            endcase
            if ((kind == K_SHL || kind == K_SHR) && cnt == 5'h00) begin
                // Flags still follow the unchanged operand; carry kept
                psw_r[cpu_ops_pkg::PSW_Z] <= (opcode == cpu_ops_pkg::OP_SHL_B)
                                            ? dest_in[7:0] == 8'h00
                                            : (opcode == cpu_ops_pkg::OP_SHL_L)
                                            ? dest_in == 32'h0000_0000
                                            : dest_in[15:0] == 16'h0000;
                psw_r[cpu_ops_pkg::PSW_N] <= (opcode == cpu_ops_pkg::OP_SHL_B)
                                            ? dest_in[7]
                                            : (opcode == cpu_ops_pkg::OP_SHL_L)
                                            ? dest_in[31] : dest_in[15];
            end
        end else if (state_r == SHIFT) begin
            psw_r[cpu_ops_pkg::PSW_C] <= sh_bit;
            psw_r[cpu_ops_pkg::PSW_Z] <= res_zero;
            psw_r[cpu_ops_pkg::PSW_N] <= res_neg;
            if (right_r) begin
                if (psw_r[cpu_ops_pkg::PSW_C])
                    psw_r[cpu_ops_pkg::PSW_ST] <= 1'b1;
            end else begin
                psw_r[cpu_ops_pkg::PSW_V] <= vflag_r | sh_chg;
                if (sh_chg)
                    psw_r[cpu_ops_pkg::PSW_VT] <= 1'b1;
            end
        end else if (stk_r == 1'b0 && state_r == WAIT && kind_r_is_flag_restore) begin
            psw_r <= stack_rd_data;
        end
    end

    // Remembers that a flag restore is waiting for its stack word
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            kind_r_is_flag_restore <= 1'b0;
        end else if (tstart) begin
            kind_r_is_flag_restore <= (kind == K_FLAG_RESTORE);
        end else begin
            kind_r_is_flag_restore <= 1'b0;
        end
    end

    // Destination write-back, completion and side effects
    logic [3:0] kind_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            kind_r    <= K_NONE;
            dest_out  <= 32'h0000_0000;
            dest_we   <= 1'b0;
            done      <= 1'b0;
            irqh_r    <= 1'b0;
            io_reinit <= 1'b0;
        end else begin
            dest_we   <= 1'b0;
            done      <= 1'b0;
            io_reinit <= 1'b0;
            if (tstart) begin
                kind_r <= kind;
                irqh_r <= 1'b0;
                if (kind == K_RST) io_reinit <= 1'b1;
                if (kind == K_ORW) begin
                    dest_out <= {dest_in[31:16], or_w};
                    dest_we  <= 1'b1;
                end else if (kind == K_ORB) begin
                    dest_out <= {dest_in[31:8], or_b};
                    dest_we  <= 1'b1;
                end
            end else if (state_r == WAIT && expired) begin
                done <= 1'b1;
                irqh_r <= (kind_r == K_FLAG_RESTORE) || (kind_r == K_FLAG_SAVE);
                if (kind_r == K_POP) begin
                    dest_out <= {16'h0000, stack_rd_data};
                    dest_we  <= 1'b1;
                end else if (kind_r == K_SHL || kind_r == K_SHR) begin
                    dest_out <= work_r;
                    dest_we  <= 1'b1;
                end
            end else if (issue) begin
                irqh_r <= 1'b0;
            end
        end
    end

    // Reset pin pulse generator
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rpulse_r <= 6'h00;
        end else if (tstart && kind == K_RST) begin
            rpulse_r <= cpu_ops_pkg::RST_PULSE;
        end else if (rpulse_r != 6'h00) begin
            rpulse_r <= rpulse_r - 6'h01;
        end
    end

    assign reset_pin_pulse = rpulse_r != 6'h00;
    assign irq_hold        = irqh_r;
    assign pc_out          = pc_r;
    assign sp_out          = sp_r;
    assign psw_out         = psw_r;
endmodule // cpu_exec
`default_nettype wire

//--- cpu_exec_properties.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_exec_props (
    // Clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // Issue side
    input wire logic        issue,
    input wire logic        busy,
    input wire logic [7:0]  opcode,
    input wire logic [7:0]  count_byte,
    input wire logic [5:0]  access_extra,
    // Results
    input wire logic        done,
    input wire logic        dest_we,
    input wire logic        irq_hold,
    input wire logic        reset_pin_pulse,
    input wire logic [15:0] sp_out,
    input wire logic [15:0] pc_out,
    input wire logic [15:0] psw_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic go;
    logic onchip;
    assign go = issue && !busy;
    assign onchip = sp_out < 16'h0100 && access_extra == 6'h00;
    a_carry_set_only: assert property (go && opcode == 8'hf9 |->
        ##4 done && psw_out == ($past(psw_out, 4) | 16'h0800))
        else $error("carry set wrong");
    a_or_flags_clear: assert property (go && opcode inside {8'h80, 8'h90} |->
        ##1 dest_we && !psw_out[11] && !psw_out[13])
        else $error("or flags wrong");
    a_pop_sp_step: assert property (go && opcode == 8'hcc && onchip |->
        ##12 done && sp_out == $past(sp_out, 12) + 16'h0002)
        else $error("pop wrong");
    a_restore_irq_hold: assert property (go && opcode == 8'hf3 && onchip |->
        ##9 done && irq_hold)
        else $error("flag restore wrong");
    a_push_sp_first: assert property (go && opcode == 8'hc8 |->
        ##1 sp_out == $past(sp_out) - 16'h0002)
        else $error("push sp wrong");
    a_save_flags_zero: assert property (go && opcode == 8'hf2 && onchip |->
        ##8 done && psw_out == 16'h0000 && irq_hold)
        else $error("flag save wrong");
    a_return_sp_step: assert property (go && opcode == 8'hf0 && onchip |->
        ##12 done && sp_out == $past(sp_out, 12) + 16'h0002)
        else $error("return wrong");
    a_reset_pin_pulse: assert property (go && opcode == 8'hff |->
        ##1 reset_pin_pulse [*4] ##1 !reset_pin_pulse)
        else $error("reset pulse wrong");
    a_reset_pc_load: assert property (go && opcode == 8'hff |->
        ##16 done && pc_out == 16'h2080 && psw_out == 16'h0000)
        else $error("soft reset wrong");
    a_shift_zero_time: assert property (go && count_byte == 8'h00 &&
        opcode inside {8'h09, 8'h19, 8'h0d, 8'h08} |-> ##8 done)
        else $error("zero shift time wrong");
    a_call_sp_time: assert property (go && opcode[7:3] == 5'b00101 && onchip |->
        ##13 done && sp_out == $past(sp_out, 13) - 16'h0002)
        else $error("short call wrong");
    c_soft_reset: cover property (go && opcode == 8'hff);
    c_right_shift: cover property (go && opcode == 8'h08 && count_byte == 8'h02);
    c_reg_count: cover property (go && count_byte >= 8'h10);
endmodule // cpu_exec_props
bind cpu_exec cpu_exec_props u_props (.clk(clk), .sys_rst(sys_rst), .issue(issue),
    .busy(busy), .opcode(opcode), .count_byte(count_byte), .access_extra(access_extra),
    .done(done), .dest_we(dest_we), .irq_hold(irq_hold), .reset_pin_pulse(reset_pin_pulse),
    .sp_out(sp_out), .pc_out(pc_out), .psw_out(psw_out));
`default_nettype wire

//--- cpu_exec_test.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_exec_test;
    logic        clk, sys_rst, issue, busy, done, dest_we, stack_we, pc_we;
    logic        irq_hold, io_reinit, reset_pin_pulse, ior;
    logic [7:0]  opcode, disp_low, count_byte, count_reg_val;
    logic [5:0]  access_extra;
    logic [31:0] dest_in, dest_out, wb;
    logic [15:0] src_in, stack_rd_data, next_pc, stack_wr_data, stack_addr;
    logic [15:0] pc_out, sp_out, psw_out, sw, sa, ps, sp, pc;
    int          num_errors, tests_run, cyc;
    cpu_exec dut (.clk(clk), .sys_rst(sys_rst), .issue(issue), .opcode(opcode),
        .disp_low(disp_low), .count_byte(count_byte), .count_reg_val(count_reg_val),
        .access_extra(access_extra), .dest_in(dest_in), .src_in(src_in),
        .stack_rd_data(stack_rd_data), .next_pc(next_pc), .busy(busy), .done(done),
        .dest_out(dest_out), .dest_we(dest_we), .stack_wr_data(stack_wr_data),
        .stack_we(stack_we), .stack_addr(stack_addr), .pc_out(pc_out), .pc_we(pc_we),
        .sp_out(sp_out), .psw_out(psw_out), .irq_hold(irq_hold), .io_reinit(io_reinit),
        .reset_pin_pulse(reset_pin_pulse));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("Counts: %0d checks, %0d mismatches", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Issues one instruction, counts states to done and grabs the results
    task automatic run(input logic [7:0] op, input logic [31:0] d, input logic [15:0] rd,
                       input logic [7:0] cb, input int n);
        int k;
        k = 0;
        wb = d;
        ior = 1'b0;
        opcode <= op;
        dest_in <= d;
        stack_rd_data <= rd;
        count_byte <= cb;
        issue <= 1'b1;
        @(posedge clk);
        issue <= 1'b0;
        do begin
            @(negedge clk);
            k++;
            if (dest_we === 1'b1) wb = dest_out;
            if (stack_we === 1'b1) sw = stack_wr_data;
            if (stack_we === 1'b1) sa = stack_addr;
            if (io_reinit === 1'b1) ior = 1'b1;
        end while (done !== 1'b1 && k < 40);
        ps = psw_out;
        sp = sp_out;
        pc = pc_out;
        chk(k, n);
        @(posedge clk);
        $display("test of op %h ended", op);
    endtask
    task automatic t_logic;
        src_in <= 16'h8001;
        run(8'h80, 32'h0000_00f0, 16'h0000, 8'h00, 4);
        chk({wb[15:0], ps[15:11]}, {16'h80f1, 5'b01000});
        src_in <= 16'h0000;
        run(8'h90, 32'h1234_5600, 16'h0000, 8'h00, 4);
        chk({wb[7:0], ps[15:11]}, {8'h00, 5'b10000});
        run(8'hf9, 32'h0, 16'h0000, 8'h00, 4);
        chk(ps, 16'h8800);
    endtask
    task automatic t_stack;
        src_in <= 16'hbeef;
        run(8'hc8, 32'h0, 16'h0000, 8'h00, 8);
        chk({sw, sa, sp}, {16'hbeef, 16'h0016, 16'h0016});
        run(8'hf2, 32'h0, 16'h0000, 8'h00, 8);
        chk({sw, sa, ps, sp}, {16'h8800, 16'h0014, 16'h0000, 16'h0014});
        run(8'hf3, 32'h0, 16'h4900, 8'h00, 9);
        chk({ps, sp}, {16'h4900, 16'h0016});
        run(8'hcc, 32'h0, 16'h1357, 8'h00, 12);
        chk({wb[15:0], sp}, {16'h1357, 16'h0018});
        next_pc <= 16'h2100;
        disp_low <= 8'h10;
        run(8'h2f, 32'h0, 16'h0000, 8'h00, 13);
        chk({sw, pc, sp}, {16'h2100, 16'h2010, 16'h0016});
        run(8'hf0, 32'h0, 16'h3000, 8'h00, 12);
        chk({pc, sp}, {16'h3000, 16'h0018});
    endtask
    task automatic t_shift;
        count_reg_val <= 8'h01;
        run(8'h09, 32'h2001, 16'h0000, 8'h03, 10);
        chk({wb[15:0], ps[15:11], ps[8]}, {16'h0008, 6'b001111});
        run(8'h19, 32'h0081, 16'h0000, 8'h20, 8);
        chk({wb[7:0], ps[11]}, {8'h02, 1'b1});
        run(8'h0d, 32'h8000_0001, 16'h0000, 8'h01, 8);
        chk({wb, ps[11]}, {32'h0000_0002, 1'b1});
        run(8'h08, 32'h0003, 16'h0000, 8'h02, 9);
        chk({wb[15:0], ps[15:11], ps[8]}, {16'h0000, 6'b100111});
        run(8'h09, 32'h1234, 16'h0000, 8'h00, 8);
        chk({wb[15:0], ps[11]}, {16'h1234, 1'b1});
        run(8'h08, 32'h0001_0002, 16'h0000, 8'h01, 8);
        chk({wb[15:0], ps[13], ps[11], ps[8]}, {16'h0001, 3'b000});
        run(8'hff, 32'h0, 16'h0000, 8'h00, 16);
        chk({pc, ps, ior}, {16'h2080, 16'h0000, 1'b1});
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Cuts a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            num_errors++;
            end_of_test;
        end
    end
    initial begin
        sys_rst = 1'b1;
        {issue, opcode, disp_low, count_byte, count_reg_val, access_extra} = '0;
        {dest_in, src_in, stack_rd_data, next_pc} = '0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        t_logic;
        t_stack;
        t_shift;
        end_of_test;
    end
endmodule // cpu_exec_test
`default_nettype wire
